//--- fph_hs_if.sv
`timescale 1ns/10ps
interface fph_hs_if #(
    parameter int NPORT = fph_pkg::NPORT,
    parameter int LVL_W = fph_pkg::LVL_W
);
    logic ctl_n;
    logic sel_n;
    logic [fph_pkg::PORT_W-1:0] port;
    logic [NPORT*LVL_W-1:0] lvl;
    logic [LVL_W-1:0] thresh;
    logic rdy;

    modport drv (output ctl_n, output sel_n, output port, output lvl, output thresh, input rdy);
    modport eng (input ctl_n, input sel_n, input port, input lvl, input thresh, output rdy);
endinterface

//--- fph_mstr.sv
`timescale 1ns/10ps
module fph_mstr (
    input wire logic clk_sys,
    output logic ctl_n,
    output logic sel_n,
    output logic [fph_pkg::PORT_W-1:0] port,
    input wire logic rdy
);
    initial begin
        ctl_n = 1'b1;
        sel_n = 1'b1;
        port = '0;
    end
    task automatic strobe(input logic [fph_pkg::PORT_W-1:0] p);
        @(posedge clk_sys);
        ctl_n <= 1'b0;
        port <= p;
        @(posedge clk_sys);
        ctl_n <= 1'b1;
    endtask
    // bounded: 9 means ready never came
    task automatic wait_rdy(output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (rdy !== 1'b1 && n < 9);
    endtask
    task automatic sel(output int n);
        sel_n <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (rdy !== 1'b0 && n < 9);
    endtask
    // second strobe lands while select is still low, so release gates it
    task automatic xfer(input logic [fph_pkg::PORT_W-1:0] p, output int up, dn, up2);
        int d2;
        dn = 0;
        up2 = 0;
        strobe(p);
        wait_rdy(up);
        if (up < 9) begin
            sel(dn);
            strobe(p);
            sel_n <= 1'b1;
            wait_rdy(up2);
            sel(d2);
        end
        sel_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask
endmodule // fph_mstr

//--- fph_pkg.sv
package fph_pkg;
    localparam int NPORT = 8;
    localparam int PORT_W = 3;
    // fifo holds 256 bytes, so levels run 0..256
    localparam int LVL_W = 9;
    // all handshake figures are in bus clock cycles
    localparam int CTL_LAG_CYC = 2;
    localparam int SEL_DROP_CYC = 2;
    localparam int SEL_GAP_CYC = 2;
    localparam int RST_MIN_CYC = 10;
    localparam int AGE_W = 2;
    localparam logic [AGE_W-1:0] AGE_MAX = 2'h3;
    // control age is cleared on the strobe edge itself, hence one less
    localparam logic [AGE_W-1:0] CTL_AGE_MIN = AGE_W'(CTL_LAG_CYC - 1);
    localparam logic [AGE_W-1:0] REL_AGE_MIN = AGE_W'(SEL_GAP_CYC);
    localparam logic [AGE_W-1:0] CTL_AGE_RST = 2'h0;
    localparam logic [AGE_W-1:0] REL_AGE_RST = 2'h3;
endpackage

//--- fph_rdy_eng.sv
`timescale 1ns/10ps
module fph_rdy_eng #(
    parameter int NPORT = fph_pkg::NPORT,
    parameter int LVL_W = fph_pkg::LVL_W
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    fph_hs_if.eng hs
);
    typedef struct packed {
        logic sel_prev;
        logic fall1;
        logic fall2;
        logic armed;
        logic [fph_pkg::AGE_W-1:0] ctl_age;
        logic [fph_pkg::AGE_W-1:0] rel_age;
        logic [fph_pkg::PORT_W-1:0] port;
        logic rdy;
    } fph_eng_st_t;

    fph_eng_st_t st_q;
    fph_eng_st_t st_d;
    logic [LVL_W-1:0] lvl_sel;
    logic meet;
    logic fall_now;

    assign lvl_sel = hs.lvl[st_q.port*LVL_W +: LVL_W];
    assign meet = (lvl_sel >= hs.thresh);
    assign fall_now = !hs.sel_n && st_q.sel_prev;
    assign hs.rdy = st_q.rdy;

    always_comb begin
        st_d = st_q;
        st_d.sel_prev = hs.sel_n;
        st_d.fall1 = fall_now;
        st_d.fall2 = st_q.fall1;
        if (st_q.ctl_age != fph_pkg::AGE_MAX) begin
            st_d.ctl_age = st_q.ctl_age + 2'h1;
        end
        if (!hs.sel_n) begin
            st_d.rel_age = 2'h0;
        end else if (st_q.rel_age != fph_pkg::AGE_MAX) begin
            st_d.rel_age = st_q.rel_age + 2'h1;
        end
        if (!hs.ctl_n) begin
            st_d.armed = 1'b1;
            st_d.ctl_age = fph_pkg::CTL_AGE_RST;
            st_d.port = hs.port;
        end
        if (st_q.fall2) begin
            st_d.rdy = 1'b0;
            // a strobe landing on the drop edge still arms, so it is not lost
            st_d.armed = !hs.ctl_n;
        end else if (fall_now || st_q.fall1) begin
            // hold through the select lag so the fall lands exactly
            st_d.rdy = st_q.rdy && meet;
        end else if (!hs.sel_n) begin
            st_d.rdy = 1'b0;
        end else begin
            st_d.rdy = st_q.armed && meet && (st_q.ctl_age >= fph_pkg::CTL_AGE_MIN)
                && (st_q.rel_age >= fph_pkg::REL_AGE_MIN) && hs.ctl_n;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '{sel_prev: 1'b1, fall1: 1'b0, fall2: 1'b0, armed: 1'b0,
                      ctl_age: fph_pkg::CTL_AGE_RST, rel_age: fph_pkg::REL_AGE_RST,
                      port: '0, rdy: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    a_ctl_rise_lag: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        $fell(hs.ctl_n) |-> ##1 !$rose(hs.rdy) ##1 !$rose(hs.rdy))
        else $error("ready rose within two cycles of control strobe");
    a_sel_drop_exact: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        $fell(hs.sel_n) |-> ##3 !hs.rdy)
        else $error("ready not low two cycles after select");
    a_sel_drop_hold: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        ($fell(hs.sel_n) && hs.rdy && meet) ##1 meet |-> hs.rdy ##1 hs.rdy)
        else $error("ready fell early after select");
    a_rel_gap_rise: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        $rose(hs.rdy) |-> $past(hs.sel_n) && $past(hs.sel_n, 2) && $past(hs.sel_n, 3))
        else $error("ready rose within two cycles of select release");
    a_thresh_gate: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        hs.rdy |-> $past(meet))
        else $error("ready high with threshold not met");
endmodule // fph_rdy_eng

//--- fph_ready_top.sv
`timescale 1ns/10ps
module fph_ready_top #(
    parameter int NPORT = fph_pkg::NPORT,
    parameter int LVL_W = fph_pkg::LVL_W
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic tx_ctl_n,
    input wire logic tx_sel_n,
    input wire logic [fph_pkg::PORT_W-1:0] tx_port,
    input wire logic [NPORT*LVL_W-1:0] tx_free,
    input wire logic [LVL_W-1:0] tx_thresh,
    input wire logic rx_ctl_n,
    input wire logic rx_sel_n,
    input wire logic [fph_pkg::PORT_W-1:0] rx_port,
    input wire logic [NPORT*LVL_W-1:0] rx_fill,
    input wire logic [LVL_W-1:0] rx_thresh,
    input wire logic tx_sop,
    input wire logic tx_eop,
    input wire logic tx_pad_req,
    input wire logic tx_crc_err_req,
    input wire logic tx_line_err_req,
    output logic tx_rdy,
    output logic rx_rdy,
    output logic tx_asis
);
    typedef struct packed {
        logic asis;
    } fph_top_st_t;

    fph_top_st_t st_q;
    fph_top_st_t st_d;

    fph_hs_if #(.NPORT(NPORT), .LVL_W(LVL_W)) tx_hs ();
    fph_hs_if #(.NPORT(NPORT), .LVL_W(LVL_W)) rx_hs ();

    assign tx_hs.ctl_n = tx_ctl_n;
    assign tx_hs.sel_n = tx_sel_n;
    assign tx_hs.port = tx_port;
    assign tx_hs.lvl = tx_free;
    assign tx_hs.thresh = tx_thresh;
    assign rx_hs.ctl_n = rx_ctl_n;
    assign rx_hs.sel_n = rx_sel_n;
    assign rx_hs.port = rx_port;
    assign rx_hs.lvl = rx_fill;
    assign rx_hs.thresh = rx_thresh;
    assign tx_rdy = tx_hs.rdy;
    assign rx_rdy = rx_hs.rdy;
    assign tx_asis = st_q.asis;

    fph_rdy_eng #(.NPORT(NPORT), .LVL_W(LVL_W)) u_tx_eng (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .hs(tx_hs.eng)
    );

    fph_rdy_eng #(.NPORT(NPORT), .LVL_W(LVL_W)) u_rx_eng (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .hs(rx_hs.eng)
    );

    always_comb begin
        st_d = st_q;
        // one-packet words carry both marks; the start condition wins there
        if (tx_sop) begin
            st_d.asis = !tx_pad_req && !tx_crc_err_req;
        end else if (tx_eop) begin
            st_d.asis = tx_line_err_req;
        end else begin
            st_d.asis = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '{asis: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    a_asis_start: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        tx_sop |=> (tx_asis == !($past(tx_pad_req) || $past(tx_crc_err_req))))
        else $error("as-is qualifier wrong at packet start");
    a_asis_end: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (tx_eop && !tx_sop) |=> (tx_asis == $past(tx_line_err_req)))
        else $error("as-is qualifier wrong at packet end");
    a_asis_idle: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (!tx_sop && !tx_eop) |=> !tx_asis)
        else $error("as-is qualifier high outside packet edges");
endmodule // fph_ready_top

//--- tb.sv
`timescale 1ns/10ps
module tb;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic tx_ctl_n, tx_sel_n, rx_ctl_n, rx_sel_n, tx_rdy, rx_rdy, tx_asis;
    logic [fph_pkg::PORT_W-1:0] tx_port, rx_port;
    logic [fph_pkg::NPORT*fph_pkg::LVL_W-1:0] tx_free, rx_fill;
    logic [fph_pkg::LVL_W-1:0] tx_thresh, rx_thresh;
    logic tx_sop, tx_eop, tx_pad_req, tx_crc_err_req, tx_line_err_req;
    int error_cnt = 0;
    int checked = 0;
    int up, dn, up2;
    always #5 clk_sys = ~clk_sys;
    fph_ready_top dut (.clk_sys(clk_sys), .arst_n(arst_n), .tx_ctl_n(tx_ctl_n),
        .tx_sel_n(tx_sel_n), .tx_port(tx_port), .tx_free(tx_free), .tx_thresh(tx_thresh),
        .rx_ctl_n(rx_ctl_n), .rx_sel_n(rx_sel_n), .rx_port(rx_port), .rx_fill(rx_fill),
        .rx_thresh(rx_thresh), .tx_sop(tx_sop), .tx_eop(tx_eop), .tx_pad_req(tx_pad_req),
        .tx_crc_err_req(tx_crc_err_req), .tx_line_err_req(tx_line_err_req),
        .tx_rdy(tx_rdy), .rx_rdy(rx_rdy), .tx_asis(tx_asis));
    fph_mstr txm (.clk_sys(clk_sys), .ctl_n(tx_ctl_n), .sel_n(tx_sel_n), .port(tx_port),
        .rdy(tx_rdy));
    fph_mstr rxm (.clk_sys(clk_sys), .ctl_n(rx_ctl_n), .sel_n(rx_sel_n), .port(rx_port),
        .rdy(rx_rdy));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic summarize();
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic t_tx();
        txm.xfer(3'h6, up, dn, up2);
        cmp(8'(up), 8'h03);
        cmp(8'(dn), 8'h04);
        cmp(8'(up2), 8'h04);
        $display("t_tx done");
    endtask
    task automatic t_rx();
        rxm.xfer(3'h1, up, dn, up2);
        cmp(8'(up), 8'h03);
        cmp(8'(dn), 8'h04);
        cmp(8'(up2), 8'h04);
        $display("t_rx done");
    endtask
    // port 5 one short of threshold, port 4 exactly on it
    task automatic t_thresh();
        tx_free[5*9 +: 9] <= 9'h03f;
        tx_free[4*9 +: 9] <= 9'h040;
        txm.xfer(3'h5, up, dn, up2);
        cmp(8'(up), 8'h09);
        txm.xfer(3'h4, up, dn, up2);
        cmp(8'(up), 8'h03);
        $display("t_thresh done");
    endtask
    task automatic t_asis();
        // last pass carries both marks with a line error, so the start must win
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            tx_sop <= (i < 4 || i == 7);
            tx_eop <= (i >= 4);
            tx_pad_req <= i[0];
            tx_crc_err_req <= i[1];
            tx_line_err_req <= i[0];
            @(posedge clk_sys);
            tx_sop <= 1'b0;
            tx_eop <= 1'b0;
            @(posedge clk_sys);
            cmp({7'h00, tx_asis}, {7'h00, (i == 0 || i == 5)});
        end
        $display("t_asis done");
    endtask
    initial begin
        #100us;
        error_cnt++;
        summarize();
    end
    initial begin
        tx_free = {8{9'h100}};
        rx_fill = {8{9'h080}};
        tx_thresh = 9'h040;
        rx_thresh = 9'h080;
        {tx_sop, tx_eop, tx_pad_req, tx_crc_err_req, tx_line_err_req} = 5'h00;
        repeat (12) @(posedge clk_sys);
        cmp({5'h00, tx_rdy, rx_rdy, tx_asis}, 8'h00);
        arst_n <= 1'b1;
        t_tx();
        t_rx();
        t_thresh();
        t_asis();
        summarize();
    end
endmodule // tb
